// ---- design/rio_int_ctrl.sv ----
// Interrupt output controller with flags, control register and AXI4-Lite slave.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module rio_int_ctrl #(
   parameter int MS_TICK_CYC  = rio_pkg::MS_CYC,
   parameter int REL_TIME_CYC = rio_pkg::REL_CYC
) (
   input  wire logic                    sys_clk,
   input  wire logic                    reset,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [rio_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]              s_axi_awprot,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   output logic [1:0]                   s_axi_bresp,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   input  wire logic [rio_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]              s_axi_arprot,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready,
   output logic [31:0]                  s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   input  wire rio_pkg::rio_event_type  events,
   output logic                         comp_start,
   output logic [1:0]                   comp_interval_sel,
   output logic                         subsec_clear,
   output logic                         int_pin_out,
   output logic                         int_pin_oe,
   output logic                         irq
);
   import rio_pkg::*;

   generate
      if (MS_TICK_CYC < 1 || REL_TIME_CYC < 2) begin : g_bad
         $error("tick or release count too small");
      end
   endgenerate

   rio_state_type   q;
   rio_state_type   d;
   logic            rd_fire;
   logic            wr_fire;
   logic [5:0]      rd_idx_in;
   logic            wr_flag;
   logic            wr_ctrl;
   logic            wr_mask;
   logic [1:0]      rel_start;
   logic [1:0]      rel_cancel;
   logic [1:0]      rel_act;
   logic [NSRC-1:0] src_vec;
   logic [15:0]     period_ms;
   logic [7:0]      rd_mux;
   logic            rd_hit;
   logic            pin_zero_q;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   assign rd_fire   = s_axi_arvalid && q.arready;
   assign wr_fire   = q.aw_have && q.w_have && !q.bvalid;
   assign rd_idx_in = s_axi_araddr[7:2];
   assign wr_flag   = wr_fire && q.wstrb0 &&
                      (q.aw_idx == IDX_FLAG_A || q.aw_idx == IDX_FLAG_B);
   assign wr_ctrl   = wr_fire && q.wstrb0 &&
                      (q.aw_idx == IDX_CTRL_A || q.aw_idx == IDX_CTRL_B);
   assign wr_mask   = wr_fire && q.wstrb0 && q.aw_idx == IDX_IRQ_MASK;
   assign src_vec   = events;

   // ----------------------------------------------------------------
   // Auto-release sources: update and fixed-cycle timer
   // ----------------------------------------------------------------
   assign rel_start[0]  = events.update && q.ctrl.update_irq_en; // [RULE9]
   assign rel_cancel[0] = !q.ctrl.update_irq_en;                 // [RULE9]
   assign rel_start[1]  = events.timer && q.ctrl.timer_irq_en;   // [RULE11]
   assign rel_cancel[1] = !q.ctrl.timer_irq_en;                  // [RULE11]

   generate
      for (genvar i = 0; i < 2; i++) begin : g_rel
         rio_release_timer #(
            .COUNT (REL_TIME_CYC)
         ) u_rel (
            .sys_clk (sys_clk),
            .reset   (reset),
            .start   (rel_start[i]),
            .cancel  (rel_cancel[i]),
            .active  (rel_act[i])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Read data and compensation period
   // ----------------------------------------------------------------
   always_comb begin
      rd_hit = 1'b1;
      case (rd_idx_in)
         IDX_FLAG_A, IDX_FLAG_B: begin
            rd_mux = {2'h0, q.flags.update_event_flag, q.flags.timer_event_flag,
                      q.flags.alarm_event_flag, q.flags.ext_event_flag,
                      1'h0, q.flags.comp_stop};
         end
         IDX_CTRL_A, IDX_CTRL_B: begin
            rd_mux = {q.ctrl.sel, q.ctrl.update_irq_en, q.ctrl.timer_irq_en,
                      q.ctrl.alarm_irq_en, q.ctrl.ext_event_irq_en,
                      1'h0, q.ctrl.clkrst}; // [RULE5] [RULE6]
         end
         IDX_IRQ_STAT: begin
            rd_mux = {3'h0, q.irq_status};
         end
         IDX_IRQ_MASK: begin
            rd_mux = {3'h0, q.irq_mask};
         end
         default: begin
            rd_mux = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
      case (q.ctrl.sel)
         2'h0:    period_ms = COMP_T00_MS; // [RULE7]
         2'h1:    period_ms = COMP_T01_MS;
         2'h2:    period_ms = COMP_T10_MS;
         default: period_ms = COMP_T11_MS;
      endcase
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      d            = q;
      d.comp_start = 1'b0;
      if (q.awready && s_axi_awvalid) begin
         d.aw_have = 1'b1;
         d.aw_idx  = s_axi_awaddr[7:2];
      end
      if (q.wready && s_axi_wvalid) begin
         d.w_have = 1'b1;
         d.wdata  = s_axi_wdata[7:0];
         d.wstrb0 = s_axi_wstrb[0];
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      if (wr_fire) begin
         d.aw_have = 1'b0;
         d.w_have  = 1'b0;
         d.bvalid  = 1'b1;
         d.bresp   = (q.aw_idx == IDX_FLAG_A || q.aw_idx == IDX_FLAG_B ||
                      q.aw_idx == IDX_CTRL_A || q.aw_idx == IDX_CTRL_B ||
                      q.aw_idx == IDX_IRQ_STAT || q.aw_idx == IDX_IRQ_MASK) ?
                     RESP_OKAY : RESP_SLVERR;
      end
      d.awready = !d.aw_have;
      d.wready  = !d.w_have;
      if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      if (rd_fire) begin
         d.rvalid = 1'b1;
         d.rd_idx = rd_idx_in;
         d.rdata  = rd_mux;
         d.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      d.arready = !d.rvalid;

      // Software clears by writing zero; the set below wins a tie.
      if (wr_flag) begin
         d.flags.update_event_flag = q.flags.update_event_flag & q.wdata[FLAG_UPD];
         d.flags.timer_event_flag = q.flags.timer_event_flag & q.wdata[FLAG_TMR];
         d.flags.alarm_event_flag = q.flags.alarm_event_flag & q.wdata[FLAG_ALM];
         d.flags.ext_event_flag = q.flags.ext_event_flag & q.wdata[FLAG_EXT];
         d.flags.comp_stop = q.flags.comp_stop & q.wdata[FLAG_COMP]; // [RULE2] [RULE4]
      end
      if (events.update) d.flags.update_event_flag = 1'b1; // [RULE18]
      if (events.timer) d.flags.timer_event_flag = 1'b1;
      if (events.alarm) d.flags.alarm_event_flag = 1'b1;
      if (events.ext) d.flags.ext_event_flag = 1'b1;
      if (events.comp_halt) d.flags.comp_stop = 1'b1; // [RULE1]

      if (wr_ctrl) begin
         d.ctrl.sel    = q.wdata[CTRL_SEL_HI:CTRL_SEL_LO]; // [RULE5]
         d.ctrl.update_irq_en    = q.wdata[CTRL_UPD_EN];
         d.ctrl.timer_irq_en     = q.wdata[CTRL_TMR_EN];
         d.ctrl.alarm_irq_en     = q.wdata[CTRL_ALM_EN];
         d.ctrl.ext_event_irq_en = q.wdata[CTRL_EXT_EN];
         d.ctrl.clkrst = q.wdata[CTRL_CLKRST]; // [RULE17]
      end
      if (wr_mask) begin
         d.irq_mask = q.wdata[NSRC-1:0];
      end
      if (rd_fire && rd_idx_in == IDX_IRQ_STAT) begin
         d.irq_status = '0;
      end
      d.irq_status = d.irq_status | src_vec;
      d.irq        = |(d.irq_status & d.irq_mask);

      // Latched sources: no timeout, only the flag or the enable drops them.
      if (!q.ctrl.alarm_irq_en || !q.flags.alarm_event_flag) begin
         d.alarm_act = 1'b0; // [RULE13] [RULE14]
      end
      if (events.alarm && q.ctrl.alarm_irq_en) d.alarm_act = 1'b1; // [RULE13]
      if (!q.ctrl.ext_event_irq_en || !q.flags.ext_event_flag) d.ext_act = 1'b0;
      if (events.ext && q.ctrl.ext_event_irq_en) d.ext_act = 1'b1; // [RULE16]
      d.int_oe = rel_act[0] | rel_act[1] | q.alarm_act | q.ext_act; // [RULE15]

      // Millisecond divider feeding the compensation interval counter.
      if (q.ms_div == 32'(MS_TICK_CYC - 1)) begin
         d.ms_div = 32'h0000_0000;
         if (q.ms_cnt >= period_ms - 16'h0001) begin
            d.ms_cnt     = 16'h0000;
            d.comp_start = 1'b1; // [RULE7]
         end else begin
            d.ms_cnt = q.ms_cnt + 16'h0001;
         end
      end else begin
         d.ms_div = q.ms_div + 32'h0000_0001;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         q                 <= '0;
         q.flags.comp_stop <= COMP_STOP_RST; // [RULE3]
         q.ctrl.sel        <= CTRL_SEL_RST;  // [RULE8]
         pin_zero_q        <= 1'b0;
      end else begin
         q          <= d;
         pin_zero_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign s_axi_awready     = q.awready;
   assign s_axi_wready      = q.wready;
   assign s_axi_bvalid      = q.bvalid;
   assign s_axi_bresp       = q.bresp;
   assign s_axi_arready     = q.arready;
   assign s_axi_rvalid      = q.rvalid;
   assign s_axi_rresp       = q.rresp;
   assign s_axi_rdata       = {24'h000000, q.rdata};
   assign comp_start        = q.comp_start;
   assign comp_interval_sel = q.ctrl.sel;
   assign subsec_clear      = q.ctrl.clkrst; // [RULE17]
   assign int_pin_out       = pin_zero_q;
   assign int_pin_oe        = q.int_oe;
   assign irq               = q.irq;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   sequence upd_fire_s;
      events.update && q.ctrl.update_irq_en;
   endsequence

   sequence alarm_kept_s;
      q.alarm_act && q.ctrl.alarm_irq_en && q.flags.alarm_event_flag;
   endsequence

   comp_set_a: assert property (events.comp_halt |=> q.flags.comp_stop) // [RULE1]
      else $error("stop flag not set by halt");
   comp_hold_a: assert property (q.flags.comp_stop && !(wr_flag && !q.wdata[FLAG_COMP])
                                 |=> q.flags.comp_stop) // [RULE2]
      else $error("stop flag dropped without a zero write");
   comp_clear_a: assert property (wr_flag && !q.wdata[FLAG_COMP] && !events.comp_halt
                                  |=> !q.flags.comp_stop) // [RULE4]
      else $error("stop flag not cleared by zero write");
   power_up_a: assert property (@(posedge sys_clk) disable iff (1'b0)
                                reset |=> q.flags.comp_stop &&
                                q.ctrl.sel == CTRL_SEL_RST && !int_pin_oe) // [RULE3] [RULE8]
      else $error("wrong values after reset");
   zero_bit_a: assert property (q.rvalid && (q.rd_idx == IDX_CTRL_A ||
                                q.rd_idx == IDX_CTRL_B) |-> !s_axi_rdata[1]) // [RULE6]
      else $error("fixed bit read as one");
   upd_pin_a: assert property (upd_fire_s ##1 q.ctrl.update_irq_en |=> int_pin_oe) // [RULE9]
      else $error("update event did not drive pin");
   alarm_hold_a: assert property (alarm_kept_s |=> q.alarm_act) // [RULE14]
      else $error("alarm pin released on its own");
   alarm_cancel_a: assert property (!q.ctrl.alarm_irq_en && !events.alarm
                                    |=> !q.alarm_act) // [RULE13]
      else $error("alarm not cancelled by enable");
   pin_or_a: assert property (int_pin_oe == $past(rel_act[0] | rel_act[1] |
                              q.alarm_act | q.ext_act)) // [RULE15]
      else $error("pin is not OR of sources");
   ext_gate_a: assert property (events.ext && !q.ctrl.ext_event_irq_en && !q.ext_act
                                |=> !q.ext_act) // [RULE16]
      else $error("disabled external event drove pin");
   flag_poll_a: assert property (events.update && !q.ctrl.update_irq_en
                                 |=> q.flags.update_event_flag) // [RULE18]
      else $error("update flag not set while disabled");

endmodule
`default_nettype wire

// ---- design/rio_pkg.sv ----
// Constants, register map and carrier types of the interrupt output controller.
//
// What this block does
// (RULE1) Compensation halt sets the stop flag.
// (RULE2) Stop flag holds until software writes zero.
// (RULE3) Stop flag reads one after power-up.
// (RULE4) Zero clears stop flag; one does nothing.
// (RULE5) Control register layout, mirrored at two addresses.
// (RULE6) Write-protected bits read zero, ignore writes.
// (RULE7) Interval select picks compensation period.
// (RULE8) Power-up interval select is 01, fixed zero.
// (RULE9) Update event drives pin only when enabled.
// (RULE10) Update pin low releases after 7.8 ms.
// (RULE11) Timer event drives pin only when enabled.
// (RULE12) Timer pin low releases within 7.8 ms.
// (RULE13) Alarm event drives pin only when enabled.
// (RULE14) Alarm low holds until alarm flag cleared.
// (RULE15) Pin is OR of enabled active sources.
// (RULE16) External event drives pin only when enabled.
// (RULE17) Clock reset bit clears and halts timekeeping.
// (RULE18) Event flags set regardless of enables.
package rio_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_FREQ_MHZ = 100;
   localparam int REL_TIME_US  = 7800;
   localparam int REL_CYC      = REL_TIME_US * CLK_FREQ_MHZ;
   localparam int MS_TIME_US   = 1000;
   localparam int MS_CYC       = MS_TIME_US * CLK_FREQ_MHZ;

   localparam logic [15:0] COMP_T00_MS = 16'h01F4;
   localparam logic [15:0] COMP_T01_MS = 16'h07D0;
   localparam logic [15:0] COMP_T10_MS = 16'h2710;
   localparam logic [15:0] COMP_T11_MS = 16'h7530;

   // ----------------------------------------------------------------
   // Register indices; the byte address is four times the index
   // ----------------------------------------------------------------
   localparam int          ADDR_W       = 8;
   localparam logic [5:0]  IDX_FLAG_A   = 6'h0E;
   localparam logic [5:0]  IDX_FLAG_B   = 6'h1E;
   localparam logic [5:0]  IDX_CTRL_A   = 6'h0F;
   localparam logic [5:0]  IDX_CTRL_B   = 6'h1F;
   localparam logic [5:0]  IDX_IRQ_STAT = 6'h30;
   localparam logic [5:0]  IDX_IRQ_MASK = 6'h31;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL_SEL_HI = 7;
   localparam int CTRL_SEL_LO = 6;
   localparam int CTRL_UPD_EN = 5;
   localparam int CTRL_TMR_EN = 4;
   localparam int CTRL_ALM_EN = 3;
   localparam int CTRL_EXT_EN = 2;
   localparam int CTRL_CLKRST = 0;
   localparam int FLAG_UPD    = 5;
   localparam int FLAG_TMR    = 4;
   localparam int FLAG_ALM    = 3;
   localparam int FLAG_EXT    = 2;
   localparam int FLAG_COMP   = 0;
   localparam int NSRC        = 5;

   // ----------------------------------------------------------------
   // Reset values and responses
   // ----------------------------------------------------------------
   localparam logic [1:0] CTRL_SEL_RST  = 2'h1;
   localparam logic       COMP_STOP_RST = 1'h1;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   // Packed order puts update at bit 0, matching the status layout.
   typedef struct packed {
      logic comp_halt;
      logic ext;
      logic alarm;
      logic timer;
      logic update;
   } rio_event_type;

   typedef struct packed {
      logic [1:0] sel;
      logic       update_irq_en;
      logic       timer_irq_en;
      logic       alarm_irq_en;
      logic       ext_event_irq_en;
      logic       clkrst;
   } rio_ctrl_type;

   typedef struct packed {
      logic update_event_flag;
      logic timer_event_flag;
      logic alarm_event_flag;
      logic ext_event_flag;
      logic comp_stop;
   } rio_flags_type;

   typedef struct packed {
      logic                aw_have;
      logic [5:0]          aw_idx;
      logic                w_have;
      logic [7:0]          wdata;
      logic                wstrb0;
      logic                awready;
      logic                wready;
      logic                bvalid;
      logic [1:0]          bresp;
      logic                arready;
      logic                rvalid;
      logic [1:0]          rresp;
      logic [5:0]          rd_idx;
      logic [7:0]          rdata;
      rio_flags_type       flags;
      rio_ctrl_type        ctrl;
      logic [NSRC-1:0]     irq_status;
      logic [NSRC-1:0]     irq_mask;
      logic                irq;
      logic                alarm_act;
      logic                ext_act;
      logic                int_oe;
      logic [31:0]         ms_div;
      logic [15:0]         ms_cnt;
      logic                comp_start;
   } rio_state_type;

endpackage

// ---- design/rio_release_timer.sv ----
// Auto-release timer that holds one interrupt source low for a fixed count.
`timescale 1ns/1ps
`default_nettype none
module rio_release_timer #(
   parameter int COUNT = rio_pkg::REL_CYC
) (
   input  wire logic sys_clk,
   input  wire logic reset,
   input  wire logic start,
   input  wire logic cancel,
   output logic      active
);
   import rio_pkg::*;

   localparam int CW = $clog2(COUNT);

   generate
      if (COUNT < 2) begin : g_bad
         $error("COUNT must be at least 2");
      end
   endgenerate

   typedef struct packed {
      logic          active;
      logic [CW-1:0] cnt;
   } rio_rel_state_type;

   rio_rel_state_type q;
   rio_rel_state_type d;

   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   // A new event restarts the window, so a burst never releases early.
   always_comb begin
      d = q;
      if (q.active) begin
         if (q.cnt == CW'(COUNT - 1)) begin
            d.active = 1'b0; // [RULE10] [RULE12]
         end else begin
            d.cnt = q.cnt + CW'(1);
         end
      end
      if (start) begin
         d.active = 1'b1;
         d.cnt    = '0;
      end
      if (cancel) begin
         d.active = 1'b0; // [RULE9] [RULE11]
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign active = q.active;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   start_arms_a: assert property (start && !cancel |=> active && q.cnt == '0) // [RULE10]
      else $error("release timer did not arm");
   window_end_a: assert property (active && !start && q.cnt == CW'(COUNT - 1) |=> !active) // [RULE12]
      else $error("release timer overran its window");
   cancel_drop_a: assert property (cancel |=> !active) // [RULE11]
      else $error("release timer ignored cancel");

endmodule
`default_nettype wire

// ---- dv/rio_host_model.sv ----
// Host-side model of the shared open-drain interrupt line and its pull-up.
`timescale 1ns/1ps
`default_nettype none
module rio_host_model (
   input  wire logic int_pin_out,
   input  wire logic int_pin_oe,
   output logic      pin_level
);
   // -------------------------------------------------------------
   // Wire resolution
   // -------------------------------------------------------------
   // The pull-up wins whenever the controller lets go, so a released pin reads high.
   assign pin_level = int_pin_oe ? int_pin_out : 1'b1;
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the interrupt output controller.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import rio_pkg::*;
   localparam int MS  = 2;
   localparam int REL = 40;
   localparam int PER [3] = '{500, 2000, 10000};
   logic          sys_clk, reset, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0]    awaddr, araddr, en;
   logic [31:0]   wdata, rdata, rd;
   logic          awready, wready, bvalid, arready, rvalid, comp_start;
   logic [1:0]    bresp, rresp, sel, resp;
   logic          subsec_clear, pin_out, pin_oe, irq, pin_level;
   rio_event_type events;
   int            n_fail, n_compared, n;

   rio_int_ctrl #(.MS_TICK_CYC(MS), .REL_TIME_CYC(REL)) i_rio_int_ctrl (
      .sys_clk(sys_clk), .reset(reset),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .events(events), .comp_start(comp_start),
      .comp_interval_sel(sel), .subsec_clear(subsec_clear),
      .int_pin_out(pin_out), .int_pin_oe(pin_oe), .irq(irq));

   rio_host_model i_rio_host_model (
      .int_pin_out(pin_out), .int_pin_oe(pin_oe), .pin_level(pin_level));

   // -------------------------------------------------------------
   // Bus and check tasks
   // -------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      awvalid <= 1'b1;
      awaddr  <= a;
      wvalid  <= 1'b1;
      wdata   <= {24'h0, d};
      bready  <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!(bvalid === 1'b1));
      resp = bresp;
      bready <= 1'b0;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      @(posedge sys_clk);
      arvalid <= 1'b1;
      araddr  <= a;
      rready  <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!(rvalid === 1'b1));
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
      chk(rd, exp);
   endtask

   task automatic wt(input int c);
      repeat (c) @(posedge sys_clk);
      #1;
   endtask

   // One-cycle event pulse; it is sampled at the second edge.
   task automatic pulse(input int i);
      @(posedge sys_clk);
      events <= rio_event_type'(5'h01 << i);
      @(posedge sys_clk);
      events <= '0;
   endtask

   // Counts the cycles between two consecutive compensation starts.
   task automatic gap(output int c);
      c = 0;
      do @(posedge sys_clk); while (comp_start !== 1'b1);
      do begin
         @(posedge sys_clk);
         c++;
      end while (comp_start !== 1'b1);
   endtask

   task automatic print_verdict();
      if (n_fail == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // -------------------------------------------------------------
   // Clock, watchdog and tests
   // -------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // The slowest test waits out two long compensation periods, hence the wide margin.
   initial begin
      repeat (95000) @(posedge sys_clk);
      n_fail++;
      print_verdict();
   end

   initial begin
      reset = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      events = '0;
      n_fail = 0;
      n_compared = 0;
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      wt(2);
      rdc(8'h3C, 32'h40);
      rdc(8'h78, 32'h01);
      wr(8'h7C, 8'hFF);
      chk(32'(resp), 32'(RESP_OKAY));
      rdc(8'h3C, 32'hFD);
      chk(32'(sel), 32'h3);
      chk(32'(subsec_clear), 32'h1);
      wr(8'h38, 8'h01);
      rdc(8'h38, 32'h01);
      wr(8'h38, 8'h00);
      rdc(8'h78, 32'h00);
      pulse(4);
      rdc(8'h38, 32'h01);
      for (int i = 0; i < 4; i++) begin
         en = 8'h20 >> i;
         wr(8'h3C, 8'h40);
         wr(8'h38, 8'h00);
         pulse(i);
         wt(3);
         chk(32'(pin_level), 32'h1);
         rdc(8'h38, 32'(en));
         wr(8'h38, 8'h00);
         wr(8'h3C, 8'h40 | en);
         pulse(i);
         wt(3);
         chk(32'(pin_level), 32'h0);
         wt(REL);
         chk(32'(pin_level), {31'h0, i < 2});
         wr(8'h38, 8'h00);
         wt(3);
         chk(32'(pin_level), 32'h1);
         pulse(i);
         wt(3);
         wr(8'h3C, 8'h40);
         wt(3);
         chk(32'(pin_level), 32'h1);
      end
      rdc(8'hC0, 32'h1F);
      rdc(8'hC0, 32'h00);
      wr(8'hC4, 8'h1F);
      pulse(4);
      wt(3);
      chk(32'(irq), 32'h1);
      rdc(8'hC0, 32'h10);
      wt(2);
      chk(32'(irq), 32'h0);
      wr(8'hC4, 8'h00);
      pulse(3);
      wt(3);
      chk(32'(irq), 32'h0);
      rdc(8'h00, 32'h0);
      chk(32'(resp), 32'(RESP_SLVERR));
      wr(8'h04, 8'h55);
      chk(32'(resp), 32'(RESP_SLVERR));
      for (int s = 0; s < 3; s++) begin
         wr(8'h3C, 8'(s << 6));
         gap(n);
         chk(32'(n), 32'(PER[s] * MS));
      end
      print_verdict();
   end
endmodule
`default_nettype wire
